// ### design/buck_prot_defs.svh
`ifndef BUCK_PROT_DEFS_SVH
`define BUCK_PROT_DEFS_SVH

// ==========================================
// Protection counts
`define BP_OCP_HICCUP_COUNT   4'ha
`define BP_HICCUP_OSC_CYCLES  13'h1000

// ==========================================
// Foldback tick masks (full, half, quarter rate)
`define BP_FOLD_MASK_FULL     2'h0
`define BP_FOLD_MASK_HALF     2'h1
`define BP_FOLD_MASK_QUARTER  2'h3

`endif

// ### design/buck_prot_pkg.sv
package buck_prot_pkg;

   // ==========================================
   // Synchronised comparator flags
   typedef struct packed {
      logic peak_limit;
      logic sink_limit;
      logic feedback_sense_ge_0p7;
      logic feedback_sense_gt_0p63;
      logic feedback_sense_ge_0p4;
      logic feedback_sense_ge_0p2;
      logic power_input_below_3p8;
      logic power_input_above_4p3;
      logic temp_above_150;
      logic temp_below_125;
      logic enable_above_1p17;
      logic enable_below_1p07;
   } comp_flags_s;

   localparam int COMP_FLAGS_W = $bits(comp_flags_s);

   // ==========================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_OFF        = 2'b00,
      ST_SOFT_START = 2'b01,
      ST_RUN        = 2'b10,
      ST_HICCUP     = 2'b11
   } seq_state_e;

endpackage

// ### design/flag_sync.sv
module flag_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         srst,
   // Flags
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_q;

   always_comb begin
      next_stage1 = d;
      next_q      = stage1;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         stage1 <= '0;
         q      <= '0;
      end else begin
         stage1 <= next_stage1;
         q      <= next_q;
      end
   end

endmodule

// ### design/wait_timer.sv
module wait_timer #(
   parameter int W = 13
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         srst,
   // Control
   input  wire logic [W-1:0] limit,
   input  wire logic         start,
   input  wire logic         tick,
   output logic              done
);

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic         running;
   logic         next_running;

   always_comb begin
      done         = running && tick && (count == W'(limit - 1'b1));
      next_count   = count;
      next_running = running;
      if (start) begin
         next_count   = '0;
         next_running = 1'b1;
      end else if (done) begin
         next_running = 1'b0;
      end else if (running && tick) begin
         next_count = W'(count + 1'b1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         count   <= '0;
         running <= 1'b0;
      end else begin
         count   <= next_count;
         running <= next_running;
      end
   end

endmodule

// ### design/buck_fault_protection_sequencer.sv
`include "buck_prot_defs.svh"

module buck_fault_protection_sequencer #(
   parameter logic [12:0] HICCUP_OSC_CYCLES = `BP_HICCUP_OSC_CYCLES,
   parameter int          OCP_W             = 4
) (
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      srst,
   // Oscillator and soft start ramp
   input  wire logic                      osc_tick,
   input  wire logic                      soft_start_done,
   // Comparator flags, asynchronous
   input  wire buck_prot_pkg::comp_flags_s comparators,
   // Switch drives
   output logic                           high_side_drive,
   output logic                           low_side_drive,
   // Status
   output logic                           soft_start_begin,
   output logic                           regulator_on,
   output logic                           hiccup_active,
   output buck_prot_pkg::seq_state_e      seq_state
);
   import buck_prot_pkg::*;

   // ==========================================
   // Flag synchronisers
   comp_flags_s flags;

   flag_sync #(
      .W (COMP_FLAGS_W)
   ) u_flag_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (comparators),
      .q        (flags)
   );

   // ==========================================
   // Fault latches with hysteresis
   logic input_undervoltage_lockout;
   logic thermal_lock;
   logic enabled;
   logic overvoltage_cutoff;
   logic next_input_undervoltage_lockout;
   logic next_thermal_lock;
   logic next_enabled;
   logic next_overvoltage_cutoff;
   logic fault;

   always_comb begin
      next_input_undervoltage_lockout = input_undervoltage_lockout;
      if (flags.power_input_below_3p8) begin
         next_input_undervoltage_lockout = 1'b1;
      end else if (flags.power_input_above_4p3) begin
         next_input_undervoltage_lockout = 1'b0;
      end
      next_thermal_lock = thermal_lock;
      if (flags.temp_above_150) begin
         next_thermal_lock = 1'b1;
      end else if (flags.temp_below_125) begin
         next_thermal_lock = 1'b0;
      end
      next_enabled = enabled;
      if (flags.enable_below_1p07) begin
         next_enabled = 1'b0;
      end else if (flags.enable_above_1p17) begin
         next_enabled = 1'b1;
      end
      next_overvoltage_cutoff = overvoltage_cutoff;
      if (flags.feedback_sense_ge_0p7) begin
         next_overvoltage_cutoff = 1'b1;
      end else if (!flags.feedback_sense_gt_0p63) begin
         next_overvoltage_cutoff = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         input_undervoltage_lockout <= 1'b1;
         thermal_lock               <= 1'b0;
         enabled                    <= 1'b0;
         overvoltage_cutoff         <= 1'b0;
      end else begin
         input_undervoltage_lockout <= next_input_undervoltage_lockout;
         thermal_lock               <= next_thermal_lock;
         enabled                    <= next_enabled;
         overvoltage_cutoff         <= next_overvoltage_cutoff;
      end
   end

   assign fault = input_undervoltage_lockout || thermal_lock || !enabled;

   // ==========================================
   // Frequency foldback
   logic [1:0] fold_cnt;
   logic [1:0] next_fold_cnt;
   logic [1:0] fold_mask;
   logic       switching;
   logic       cycle_start;

   assign switching = ((seq_state == ST_SOFT_START) || (seq_state == ST_RUN)) && !overvoltage_cutoff;

   always_comb begin
      fold_mask = `BP_FOLD_MASK_FULL;
      if (seq_state == ST_SOFT_START) begin
         if (flags.feedback_sense_ge_0p4) begin
            fold_mask = `BP_FOLD_MASK_FULL;
         end else if (flags.feedback_sense_ge_0p2) begin
            fold_mask = `BP_FOLD_MASK_HALF;
         end else begin
            fold_mask = `BP_FOLD_MASK_QUARTER;
         end
      end
      cycle_start   = switching && osc_tick && ((fold_cnt & fold_mask) == `BP_FOLD_MASK_FULL);
      next_fold_cnt = fold_cnt;
      if (!switching) begin
         next_fold_cnt = 2'h0;
      end else if (osc_tick) begin
         next_fold_cnt = 2'(fold_cnt + 2'h1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         fold_cnt <= 2'h0;
      end else begin
         fold_cnt <= next_fold_cnt;
      end
   end

   // ==========================================
   // Cycle-by-cycle switch drive
   logic next_high_side_drive;
   logic next_low_side_drive;
   logic sink_block;
   logic next_sink_block;
   logic ocp_event;

   always_comb begin
      next_high_side_drive = high_side_drive;
      next_low_side_drive  = low_side_drive;
      next_sink_block      = sink_block;
      ocp_event            = 1'b0;
      if (!switching) begin
         next_high_side_drive = 1'b0;
         next_low_side_drive  = 1'b0;
         next_sink_block      = 1'b0;
      end else if (cycle_start) begin
         next_high_side_drive = 1'b1;
         next_low_side_drive  = 1'b0;
         next_sink_block      = 1'b0;
      end else if (low_side_drive && flags.sink_limit) begin
         next_high_side_drive = 1'b0;
         next_low_side_drive  = 1'b0;
         next_sink_block      = 1'b1;
      end else if (high_side_drive && flags.peak_limit) begin
         next_high_side_drive = 1'b0;
         next_low_side_drive  = !sink_block;
         ocp_event            = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         high_side_drive <= 1'b0;
         low_side_drive  <= 1'b0;
         sink_block      <= 1'b0;
      end else begin
         high_side_drive <= next_high_side_drive;
         low_side_drive  <= next_low_side_drive;
         sink_block      <= next_sink_block;
      end
   end

   // ==========================================
   // Hiccup wait timer
   logic timer_start;
   logic hiccup_done;

   wait_timer #(
      .W (13)
   ) u_hiccup_timer (
      .core_clk (core_clk),
      .srst     (srst),
      .limit    (HICCUP_OSC_CYCLES),
      .start    (timer_start),
      .tick     (osc_tick),
      .done     (hiccup_done)
   );

   // ==========================================
   // Sequencer
   seq_state_e       next_seq_state;
   logic [OCP_W-1:0] ocp_cnt;
   logic [OCP_W-1:0] next_ocp_cnt;
   logic             next_soft_start_begin;
   logic             ocp_hit;

   assign ocp_hit = (ocp_cnt >= OCP_W'(`BP_OCP_HICCUP_COUNT));

   always_comb begin
      next_seq_state        = seq_state;
      next_soft_start_begin = 1'b0;
      timer_start           = 1'b0;
      next_ocp_cnt          = ocp_cnt;
      if (ocp_event && !ocp_hit) begin
         next_ocp_cnt = OCP_W'(ocp_cnt + 1'b1);
      end
      case (seq_state)
         ST_OFF: begin
            if (!fault) begin
               next_seq_state        = ST_SOFT_START;
               next_soft_start_begin = 1'b1;
               next_ocp_cnt          = '0;
            end
         end
         ST_SOFT_START: begin
            if (ocp_hit) begin
               next_seq_state = ST_HICCUP;
               timer_start    = 1'b1;
               next_ocp_cnt   = '0;
            end else if (soft_start_done) begin
               next_seq_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ocp_hit || !flags.feedback_sense_ge_0p4) begin
               next_seq_state = ST_HICCUP;
               timer_start    = 1'b1;
               next_ocp_cnt   = '0;
            end
         end
         ST_HICCUP: begin
            if (hiccup_done) begin
               if (flags.peak_limit) begin
                  timer_start = 1'b1;
               end else begin
                  next_seq_state        = ST_SOFT_START;
                  next_soft_start_begin = 1'b1;
                  next_ocp_cnt          = '0;
               end
            end
         end
         default: begin
            next_seq_state = ST_OFF;
         end
      endcase
      if (fault) begin
         next_seq_state        = ST_OFF;
         next_soft_start_begin = 1'b0;
         next_ocp_cnt          = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         seq_state        <= ST_OFF;
         ocp_cnt          <= '0;
         soft_start_begin <= 1'b0;
         regulator_on     <= 1'b0;
         hiccup_active    <= 1'b0;
      end else begin
         seq_state        <= next_seq_state;
         ocp_cnt          <= next_ocp_cnt;
         soft_start_begin <= next_soft_start_begin;
         regulator_on     <= (next_seq_state != ST_OFF);
         hiccup_active    <= (next_seq_state == ST_HICCUP);
      end
   end

   // ==========================================
   // Checks
   a_drive_exclusive: assert property (@(posedge core_clk) disable iff (srst)
      !(high_side_drive && low_side_drive))
      else $error("both drives on");
   a_peak_swap: assert property (@(posedge core_clk) disable iff (srst)
      (switching && !cycle_start && high_side_drive && !low_side_drive && flags.peak_limit)
      |=> !high_side_drive && low_side_drive)
      else $error("high side not cut on peak limit");
   a_ocp_count: assert property (@(posedge core_clk) disable iff (srst)
      (ocp_event && !ocp_hit && !fault && (next_seq_state == seq_state))
      |=> (ocp_cnt == OCP_W'($past(ocp_cnt) + 1'b1)))
      else $error("overcurrent counter did not advance");
   a_ocp_hiccup: assert property (@(posedge core_clk) disable iff (srst)
      (ocp_hit && !fault && ((seq_state == ST_SOFT_START) || (seq_state == ST_RUN)))
      |=> (seq_state == ST_HICCUP) && (ocp_cnt == '0))
      else $error("no hiccup at overcurrent count");
   a_low_fb_hiccup: assert property (@(posedge core_clk) disable iff (srst)
      ((seq_state == ST_RUN) && !fault && !flags.feedback_sense_ge_0p4) |=> (seq_state == ST_HICCUP))
      else $error("no hiccup on low feedback");
   a_hiccup_off: assert property (@(posedge core_clk) disable iff (srst)
      ($past(seq_state) == ST_HICCUP) && (seq_state == ST_HICCUP) |-> !high_side_drive && !low_side_drive)
      else $error("drive active in hiccup");
   a_hiccup_retry: assert property (@(posedge core_clk) disable iff (srst)
      ((seq_state == ST_HICCUP) && hiccup_done && !fault)
      |=> (seq_state == ($past(flags.peak_limit) ? ST_HICCUP : ST_SOFT_START)))
      else $error("wrong restart decision");
   a_sink_cut: assert property (@(posedge core_clk) disable iff (srst)
      (switching && !cycle_start && low_side_drive && flags.sink_limit)
      |=> !low_side_drive && !high_side_drive)
      else $error("low side not cut on sink limit");
   a_overvolt_off: assert property (@(posedge core_clk) disable iff (srst)
      overvoltage_cutoff && $past(overvoltage_cutoff) |-> !high_side_drive && !low_side_drive)
      else $error("drive active during overvoltage");
   a_fault_shutdown: assert property (@(posedge core_clk) disable iff (srst)
      fault |=> (seq_state == ST_OFF) ##1 (!high_side_drive && !low_side_drive))
      else $error("fault did not shut down");
   a_restart_softstart: assert property (@(posedge core_clk) disable iff (srst)
      ((seq_state == ST_OFF) && !fault) |=> (seq_state == ST_SOFT_START) && soft_start_begin)
      else $error("no soft start after fault cleared");
   a_foldback_skip: assert property (@(posedge core_clk) disable iff (srst)
      ((seq_state == ST_SOFT_START) && !flags.feedback_sense_ge_0p4 && fold_cnt[0]) |-> !cycle_start)
      else $error("foldback did not skip a cycle");

endmodule

// ### dv/buck_front_model.sv
// ==========================================
// Comparators and oscillator seen by the sequencer
module buck_front_model (
   // Clock and drives
   input  wire logic                 core_clk,
   input  wire logic                 high_side_drive,
   input  wire logic                 low_side_drive,
   // Levels in mV and degrees C
   input  wire logic [15:0]          fb_mv,
   input  wire logic [15:0]          vin_mv,
   input  wire logic [15:0]          en_mv,
   input  wire logic [15:0]          temp_c,
   // Trip delays in cycles, zero never, and a peak limit hold
   input  wire logic [3:0]           peak_after,
   input  wire logic [3:0]           sink_after,
   input  wire logic                 peak_hold,
   // Outputs
   output wire  buck_prot_pkg::comp_flags_s comparators,
   output logic                            osc_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   import buck_prot_pkg::*;

   logic [3:0] osc_cnt = 4'h0;
   logic [3:0] hs_cnt  = 4'h0;
   logic [3:0] ls_cnt  = 4'h0;

   // Changes only at falling edges
   always @(negedge core_clk) begin
      osc_cnt <= osc_cnt + 4'h1;
      hs_cnt  <= !high_side_drive ? 4'h0 : (hs_cnt == 4'hf ? hs_cnt : hs_cnt + 4'h1);
      ls_cnt  <= !low_side_drive ? 4'h0 : (ls_cnt == 4'hf ? ls_cnt : ls_cnt + 4'h1);
   end

   assign osc_tick = (osc_cnt == 4'h0);
   assign comparators.peak_limit = peak_hold || (peak_after != 4'h0 && hs_cnt >= peak_after);
   assign comparators.sink_limit = sink_after != 4'h0 && ls_cnt >= sink_after;
   assign comparators.feedback_sense_ge_0p7 = fb_mv >= 16'h02bc;
   assign comparators.feedback_sense_gt_0p63 = fb_mv > 16'h0276;
   assign comparators.feedback_sense_ge_0p4 = fb_mv >= 16'h0190;
   assign comparators.feedback_sense_ge_0p2 = fb_mv >= 16'h00c8;
   assign comparators.power_input_below_3p8 = vin_mv < 16'h0ed8;
   assign comparators.power_input_above_4p3 = vin_mv > 16'h10cc;
   assign comparators.temp_above_150 = temp_c > 16'h0096;
   assign comparators.temp_below_125 = temp_c < 16'h007d;
   assign comparators.enable_above_1p17 = en_mv > 16'h0492;
   assign comparators.enable_below_1p07 = en_mv < 16'h042e;
endmodule

// ### dv/buck_fault_protection_sequencer_tb_top.sv
module buck_fault_protection_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import buck_prot_pkg::*;

   // ==========================================
   // Signals
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        soft_start_done = 1'b0;
   logic [15:0] fb_mv = 16'h01f4;
   logic [15:0] vin_mv = 16'h1388;
   logic [15:0] en_mv = 16'h05dc;
   logic [15:0] temp_c = 16'h0019;
   logic [3:0]  peak_after = 4'h0;
   logic [3:0]  sink_after = 4'h0;
   logic        peak_hold = 1'b0;
   logic        osc_tick;
   comp_flags_s comparators;
   logic        high_side_drive;
   logic        low_side_drive;
   logic        soft_start_begin;
   logic        regulator_on;
   logic        hiccup_active;
   seq_state_e  seq_state;
   int          err_count = 0;
   int          compares = 0;

   always #5 core_clk = ~core_clk;

   buck_fault_protection_sequencer #(.HICCUP_OSC_CYCLES(13'h0008)) dut_u (
      .core_clk(core_clk), .srst(srst), .osc_tick(osc_tick), .soft_start_done(soft_start_done),
      .comparators(comparators), .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
      .soft_start_begin(soft_start_begin), .regulator_on(regulator_on), .hiccup_active(hiccup_active),
      .seq_state(seq_state));

   buck_front_model model_u (
      .core_clk(core_clk), .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
      .fb_mv(fb_mv), .vin_mv(vin_mv), .en_mv(en_mv), .temp_c(temp_c), .peak_after(peak_after),
      .sink_after(sink_after), .peak_hold(peak_hold), .comparators(comparators), .osc_tick(osc_tick));

   // ==========================================
   // Helpers
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic wait_st(input seq_state_e s, input int n, input string msg);
      for (int i = 0; i < n && seq_state !== s; i++) @(negedge core_clk);
      chk(seq_state === s, msg);
   endtask

   task automatic wait_drive(input logic hs, input logic ls, input int n, input string msg);
      for (int i = 0; i < n && (high_side_drive !== hs || low_side_drive !== ls); i++) @(negedge core_clk);
      chk(high_side_drive === hs && low_side_drive === ls, msg);
   endtask

   task automatic stay_off(input int n, input string msg);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(negedge core_clk);
         if (high_side_drive !== 1'b0 || low_side_drive !== 1'b0) ok = 1'b0;
      end
      chk(ok, msg);
   endtask

   task automatic wait_hiccup();
      for (int i = 0; i < 400 && hiccup_active !== 1'b1; i++) @(negedge core_clk);
   endtask

   task automatic bring_up(input logic [15:0] fb_lvl, input logic ssd);
      @(negedge core_clk);
      srst = 1'b1;
      soft_start_done = 1'b0;
      fb_mv = fb_lvl;
      vin_mv = 16'h1388;
      en_mv = 16'h05dc;
      temp_c = 16'h0019;
      peak_after = 4'h0;
      sink_after = 4'h0;
      peak_hold = 1'b0;
      repeat (3) @(negedge core_clk);
      srst = 1'b0;
      wait_st(ST_SOFT_START, 12, "no soft start");
      chk(soft_start_begin === 1'b1 && regulator_on === 1'b1, "no start pulse");
      soft_start_done = ssd;
      if (ssd) wait_st(ST_RUN, 4, "no run state");
   endtask

   task automatic count_starts(input int ticks, output int n);
      int t;
      logic prev;
      t = 0;
      n = 0;
      for (int i = 0; i < 40 && osc_tick !== 1'b1; i++) @(negedge core_clk);
      prev = high_side_drive;
      while (t < ticks) begin
         @(negedge core_clk);
         if (osc_tick) t++;
         if (high_side_drive && !prev) n++;
         prev = high_side_drive;
      end
   endtask

   task automatic hic_ticks(input int max, output int t);
      logic ok;
      ok = 1'b1;
      t = 0;
      @(negedge core_clk);
      while (hiccup_active === 1'b1 && t < max) begin
         if (high_side_drive !== 1'b0 || low_side_drive !== 1'b0) ok = 1'b0;
         if (osc_tick) t++;
         @(negedge core_clk);
      end
      // The tick that ends the wait shows as hiccup drops
      if (hiccup_active !== 1'b1 && osc_tick === 1'b1) t++;
      chk(ok, "drive on in hiccup");
   endtask

   task automatic set_level(input int sel, input logic [15:0] v);
      case (sel)
         0: vin_mv = v;
         1: temp_c = v;
         default: en_mv = v;
      endcase
   endtask

   // ==========================================
   // Scenarios
   task automatic test_foldback();
      int n;
      bring_up(16'h0064, 1'b0);
      peak_after = 4'h3;
      count_starts(4, n);
      chk(n == 1, "quarter rate");
      fb_mv = 16'h012c;
      count_starts(2, n);
      chk(n == 1, "half rate");
      fb_mv = 16'h01f4;
      count_starts(3, n);
      chk(n == 3, "full rate");
      $display("test foldback done");
   endtask

   task automatic test_peak_hiccup();
      int n;
      int t;
      logic prev;
      bring_up(16'h01f4, 1'b1);
      peak_after = 4'h3;
      wait_drive(1'b1, 1'b0, 40, "no cycle start");
      wait_drive(1'b0, 1'b1, 10, "no swap on peak");
      n = 1;
      prev = 1'b0;
      for (int i = 0; i < 400 && hiccup_active !== 1'b1; i++) begin
         @(negedge core_clk);
         if (prev && !high_side_drive) n++;
         prev = high_side_drive;
      end
      chk(hiccup_active === 1'b1 && n == 10, "hiccup count");
      hic_ticks(20, t);
      chk(t == 8, "hiccup length");
      chk(seq_state === ST_SOFT_START && soft_start_begin === 1'b1, "no restart");
      peak_after = 4'h0;
      peak_hold = 1'b1;
      wait_hiccup();
      hic_ticks(12, t);
      chk(hiccup_active === 1'b1, "restart with fault");
      peak_hold = 1'b0;
      hic_ticks(20, t);
      chk(seq_state === ST_SOFT_START, "no restart after clear");
      $display("test peak hiccup done");
   endtask

   task automatic test_sink();
      logic ok;
      bring_up(16'h01f4, 1'b1);
      peak_after = 4'h3;
      sink_after = 4'h2;
      wait_drive(1'b0, 1'b1, 60, "no low side");
      wait_drive(1'b0, 1'b0, 8, "low side kept on");
      ok = 1'b1;
      for (int i = 0; i < 20 && osc_tick !== 1'b1; i++) begin
         @(negedge core_clk);
         if (osc_tick !== 1'b1 && (high_side_drive !== 1'b0 || low_side_drive !== 1'b0)) ok = 1'b0;
      end
      @(negedge core_clk);
      chk(ok && high_side_drive === 1'b1, "sink off span");
      $display("test sink done");
   endtask

   task automatic test_ovp();
      bring_up(16'h01f4, 1'b1);
      wait_drive(1'b1, 1'b0, 40, "no start");
      fb_mv = 16'h02ee;
      repeat (6) @(negedge core_clk);
      stay_off(40, "on above 0.7 V");
      fb_mv = 16'h028a;
      stay_off(40, "on above 0.63 V");
      fb_mv = 16'h0258;
      wait_drive(1'b1, 1'b0, 40, "no resume");
      $display("test ovp done");
   endtask

   task automatic test_fb_low();
      bring_up(16'h01f4, 1'b1);
      fb_mv = 16'h012c;
      for (int i = 0; i < 10 && hiccup_active !== 1'b1; i++) @(negedge core_clk);
      chk(hiccup_active === 1'b1, "no hiccup on low feedback");
      $display("test fb low done");
   endtask

   task automatic test_lock(input int sel, input logic [15:0] bad, input logic [15:0] mid, input logic [15:0] good);
      bring_up(16'h01f4, 1'b1);
      set_level(sel, bad);
      wait_st(ST_OFF, 8, "no shutdown");
      stay_off(2, "drive when off");
      chk(regulator_on === 1'b0, "regulator still on");
      set_level(sel, mid);
      stay_off(40, "restart in band");
      chk(seq_state === ST_OFF, "left off in band");
      set_level(sel, good);
      wait_st(ST_SOFT_START, 8, "no recovery");
      chk(soft_start_begin === 1'b1, "no soft start pulse");
      $display("test lock %0d done", sel);
   endtask

   // Both drives high is never allowed
   always @(negedge core_clk) if (high_side_drive === 1'b1 && low_side_drive === 1'b1) chk(1'b0, "both drives on");

   initial begin
      test_foldback();
      test_peak_hiccup();
      test_sink();
      test_ovp();
      test_fb_low();
      test_lock(0, 16'h0dac, 16'h0fa0, 16'h1194);
      test_lock(1, 16'h00a0, 16'h008c, 16'h0078);
      test_lock(2, 16'h03e8, 16'h044c, 16'h04b0);
      give_verdict();
   end

   initial begin
      #400000;
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      give_verdict();
   end
endmodule
